// ---- common/irpc_pkg.sv ----
// Constants for the interrupt, reset and power-down control block
//------------------------------------------------------------
// Behaviour
// - Interrupt is OR of all pending event bits, each gated by its own enable.
// - Interrupt enable and status are handled through the option and status registers.
// - Bus-card mode uses one active-low request line; local mode picks one of four.
// - In bus-card mode the request line stays low until ready, then signals interrupts.
// - Merged interrupt state is readable as a bit of the status register.
// - Separate interrupt enable is ignored in local bus mode.
// - Hardware reset loads every register's reset value, samples the mode strap and starts an EEPROM read.
// - Function soft reset clears function and config registers, starts EEPROM read.
// - In bus-card mode, while soft reset bit is set the request line is low; raised when cleared.
// - Core soft reset clears core except address and config registers, no EEPROM read.
// - Power-down pin counts only when the external coder select is nonzero.
// - Asserted power-down pin powers everything down and asserts modem power-down.
// - Local mode: no bits awake; only wake enable powers down transmit alone.
// - Legacy power-down bit powers down all and overrides wake enable.
// - Local mode ignores the function enable bit for the power state.
// - After pin release the state follows the unchanged power-down and wake bits.
// - Clearing wake enable from transmit-only power-down returns to fully awake.
//------------------------------------------------------------
package irpc_pkg;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 4;
  localparam int          EV_W         = 8;
  localparam logic [3:0]  OFF_OPTION   = 4'h0;
  localparam logic [3:0]  OFF_STATUS   = 4'h1;
  localparam logic [3:0]  OFF_CONTROL  = 4'h2;
  localparam logic [3:0]  OFF_RXCTRL   = 4'h3;
  localparam logic [3:0]  OFF_EV_STAT  = 4'h4;
  localparam logic [3:0]  OFF_EV_MASK  = 4'h5;
  localparam logic [3:0]  OFF_PWR      = 4'h6;
  localparam logic [3:0]  OFF_STATION  = 4'h7;
  localparam logic [3:0]  OFF_ADDR_A   = 4'h8;
  // Option register fields
  localparam int          OPT_IRQ_EN   = 0;
  localparam int          OPT_FUNC_EN  = 1;
  localparam int          OPT_SRST     = 2;
  localparam int          OPT_SEL_LO   = 3;
  // Status register fields
  localparam int          STS_INTR     = 0;
  localparam int          STS_PD       = 1;
  localparam int          STS_IO8      = 5;
  // Control register fields
  localparam int          CTL_LEGACY_POWERDOWN_BIT    = 0;
  localparam int          CTL_WAKE     = 1;
  // Receive control register field
  localparam int          RCR_CORE_RST = 0;
  // Power register fields (read only)
  localparam int          PWR_TX       = 0;
  localparam int          PWR_RX       = 1;
  localparam int          PWR_LINK     = 2;
  localparam int          PWR_PIN      = 3;
  localparam int          PWR_MODE     = 4;
  // Reset values and reset synchroniser states
  localparam logic [15:0] RST_STATION  = 16'h0000;
  localparam logic [15:0] RST_ADDR_A   = 16'h0300;
  localparam logic [1:0]  RST_SEL      = 2'h0;
  localparam logic [7:0]  RST_EV       = 8'h00;
  localparam logic [1:0]  RSYNC_DONE   = 2'h3;
  localparam logic [1:0]  RSYNC_EDGE   = 2'h1;
endpackage

// ---- src/irpc_ctrl.sv ----
// Interrupt merge, reset scopes and power-down control
`timescale 1ns/1ps
`default_nettype none
module irpc_ctrl
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic [irpc_pkg::ADDR_W-1:0]   addr,
  input  wire logic [irpc_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output var  logic [irpc_pkg::DATA_W-1:0]   rdata,
  input  wire logic [irpc_pkg::EV_W-1:0]     core_events,
  input  wire logic                          bus_mode_strap,
  input  wire logic                          powerdown_or_txclk_pin,
  input  wire logic [1:0]                    ext_endec_select,
  output var  logic                          irq_ready_out_n,
  output var  logic [3:0]                    local_irq_pins,
  output var  logic                          irq,
  output var  logic                          modem_powerdown_out_n,
  output var  logic                          tx_powered_down,
  output var  logic                          rx_powered_down,
  output var  logic                          link_powered_down,
  output var  logic                          eeprom_read_start,
  output var  logic                          pcmcia_mode
);
  import irpc_pkg::*;

  typedef struct packed
  {
    logic [1:0]        rsync;
    logic              mode_pcmcia;
    logic              pd_s1;
    logic              pd_s2;
    logic              opt_irq_en;
    logic              opt_func_en;
    logic              opt_srst;
    logic [1:0]        opt_sel;
    logic              cfg_status_reg_pd;
    logic              io_byte;
    logic              ctl_legacy_powerdown_bit;
    logic              ctl_wake;
    logic              core_rst;
    logic [EV_W-1:0]   ev_stat;
    logic [EV_W-1:0]   ev_mask;
    logic [15:0]       station;
    logic [15:0]       addr_a;
    logic [DATA_W-1:0] rdata;
    logic              irq_n;
    logic [3:0]        lirq;
    logic              irq;
    logic              mpd_n;
    logic              tx_off;
    logic              rx_off;
    logic              link_off;
    logic              ee_start;
  } irpc_state_type;

  irpc_state_type st_r;
  irpc_state_type st_nxt;

  logic              eth_irq;
  logic              pin_pd;
  logic              all_off;
  logic              tx_pd;
  logic              ready;
  logic [DATA_W-1:0] rmux;

  //------------------------------------------------------------
  // Combinational view of current state
  //------------------------------------------------------------
  always_comb
  begin
    eth_irq = |(st_r.ev_stat & st_r.ev_mask);
    pin_pd  = (ext_endec_select != 2'h0) && st_r.pd_s2;
    if (st_r.mode_pcmcia)
    begin
      all_off = pin_pd | ~st_r.opt_func_en | st_r.cfg_status_reg_pd | st_r.ctl_legacy_powerdown_bit;
    end
    else
    begin
      all_off = pin_pd | st_r.ctl_legacy_powerdown_bit;
    end
    tx_pd = all_off | st_r.ctl_wake;
    ready = (st_r.rsync == RSYNC_DONE) && !st_r.opt_srst;
    rmux  = '0;
    unique case (addr)
      OFF_OPTION:  rmux = {11'h000, st_r.opt_sel, st_r.opt_srst, st_r.opt_func_en, st_r.opt_irq_en};
      OFF_STATUS:  rmux = {10'h000, st_r.io_byte, 3'h0, st_r.cfg_status_reg_pd, eth_irq};
      OFF_CONTROL: rmux = {14'h0000, st_r.ctl_wake, st_r.ctl_legacy_powerdown_bit};
      OFF_RXCTRL:  rmux = {15'h0000, st_r.core_rst};
      OFF_EV_STAT: rmux = {8'h00, st_r.ev_stat};
      OFF_EV_MASK: rmux = {8'h00, st_r.ev_mask};
      OFF_PWR:     rmux = {11'h000, st_r.mode_pcmcia, pin_pd, st_r.link_off, st_r.rx_off, st_r.tx_off};
      OFF_STATION: rmux = st_r.station;
      OFF_ADDR_A:  rmux = st_r.addr_a;
      default:     rmux = '0;
    endcase
  end

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rsync    = {st_r.rsync[0], 1'b1};
    st_nxt.pd_s1    = powerdown_or_txclk_pin;
    st_nxt.pd_s2    = st_r.pd_s1;
    st_nxt.ee_start = 1'b0;
    st_nxt.rdata    = rd ? rmux : '0;
    if (st_r.rsync != RSYNC_DONE)
    begin
      st_nxt.mode_pcmcia = bus_mode_strap;
      st_nxt.ee_start    = (st_r.rsync == RSYNC_EDGE);
    end
    else
    begin
      if (wr)
      begin
        unique case (addr)
          OFF_OPTION:
          begin
            st_nxt.opt_irq_en  = wdata[OPT_IRQ_EN];
            st_nxt.opt_func_en = wdata[OPT_FUNC_EN];
            st_nxt.opt_srst    = wdata[OPT_SRST];
            st_nxt.opt_sel     = wdata[OPT_SEL_LO +: 2];
            st_nxt.ee_start    = wdata[OPT_SRST] & ~st_r.opt_srst;
          end
          OFF_STATUS:
          begin
            st_nxt.cfg_status_reg_pd = wdata[STS_PD];
            st_nxt.io_byte = wdata[STS_IO8];
          end
          OFF_CONTROL:
          begin
            st_nxt.ctl_legacy_powerdown_bit = wdata[CTL_LEGACY_POWERDOWN_BIT];
            st_nxt.ctl_wake  = wdata[CTL_WAKE];
          end
          OFF_RXCTRL:  st_nxt.core_rst = wdata[RCR_CORE_RST];
          OFF_EV_STAT: st_nxt.ev_stat  = st_r.ev_stat & ~wdata[EV_W-1:0];
          OFF_EV_MASK: st_nxt.ev_mask  = wdata[EV_W-1:0];
          OFF_STATION: st_nxt.station  = wdata;
          OFF_ADDR_A:  st_nxt.addr_a   = wdata;
          default:     st_nxt.rsync    = st_nxt.rsync;
        endcase
      end
      st_nxt.ev_stat = st_nxt.ev_stat | core_events;
      if (st_r.core_rst)
      begin
        st_nxt.ev_stat   = RST_EV;
        st_nxt.ev_mask   = RST_EV;
        st_nxt.ctl_legacy_powerdown_bit = 1'b0;
        st_nxt.ctl_wake  = 1'b0;
      end
      if (st_r.opt_srst)
      begin
        st_nxt.opt_irq_en  = 1'b0;
        st_nxt.opt_func_en = 1'b0;
        st_nxt.opt_sel     = RST_SEL;
        st_nxt.cfg_status_reg_pd     = 1'b0;
        st_nxt.io_byte     = 1'b0;
        st_nxt.ctl_legacy_powerdown_bit   = 1'b0;
        st_nxt.ctl_wake    = 1'b0;
        st_nxt.core_rst    = 1'b0;
        st_nxt.ev_stat     = RST_EV;
        st_nxt.ev_mask     = RST_EV;
        st_nxt.station     = RST_STATION;
        st_nxt.addr_a      = RST_ADDR_A;
      end
    end
    // Output pins
    st_nxt.irq      = eth_irq;
    st_nxt.irq_n    = 1'b1;
    st_nxt.lirq     = 4'h0;
    if (st_nxt.mode_pcmcia)
    begin
      st_nxt.irq_n = ready & ~(eth_irq & st_r.opt_irq_en);
    end
    else
    begin
      st_nxt.lirq[st_r.opt_sel] = eth_irq;
    end
    st_nxt.mpd_n    = ~pin_pd;
    st_nxt.tx_off   = tx_pd;
    st_nxt.rx_off   = all_off;
    st_nxt.link_off = all_off;
  end

  //------------------------------------------------------------
  // State register
  //------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r          <= '0;
      st_r.station  <= RST_STATION;
      st_r.addr_a   <= RST_ADDR_A;
      st_r.irq_n    <= 1'b0;
      st_r.mpd_n    <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata                 = st_r.rdata;
  assign irq_ready_out_n       = st_r.irq_n;
  assign local_irq_pins        = st_r.lirq;
  assign irq                   = st_r.irq;
  assign modem_powerdown_out_n = st_r.mpd_n;
  assign tx_powered_down       = st_r.tx_off;
  assign rx_powered_down       = st_r.rx_off;
  assign link_powered_down     = st_r.link_off;
  assign eeprom_read_start     = st_r.ee_start;
  assign pcmcia_mode           = st_r.mode_pcmcia;

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  property p_irq_merge;
    @(posedge clk) disable iff (reset)
    (st_r.rsync == RSYNC_DONE) |=> (irq == |($past(st_r.ev_stat) & $past(st_r.ev_mask)));
  endproperty
  a_irq_merge: assert property (p_irq_merge) else $error("merged irq wrong");

  property p_status_intr;
    @(posedge clk) disable iff (reset)
    (rd && addr == OFF_STATUS && (st_r.rsync == RSYNC_DONE)) |=> (rdata[STS_INTR] == $past(eth_irq));
  endproperty
  a_status_intr: assert property (p_status_intr) else $error("status intr bit wrong");

  property p_local_route;
    @(posedge clk) disable iff (reset)
    (!st_r.mode_pcmcia && eth_irq) |=> (local_irq_pins == (4'h1 << $past(st_r.opt_sel)) && irq_ready_out_n);
  endproperty
  a_local_route: assert property (p_local_route) else $error("local irq routing wrong");

  property p_srst_low;
    @(posedge clk) disable iff (reset)
    (st_r.mode_pcmcia && st_r.opt_srst) |=> !irq_ready_out_n;
  endproperty
  a_srst_low: assert property (p_srst_low) else $error("ready line not low in soft reset");

  property p_srst_eeprom;
    @(posedge clk) disable iff (reset)
    ((st_r.rsync == RSYNC_DONE) && wr && addr == OFF_OPTION && wdata[OPT_SRST] && !st_r.opt_srst)
      |=> eeprom_read_start ##1 !eeprom_read_start;
  endproperty
  a_srst_eeprom: assert property (p_srst_eeprom) else $error("soft reset eeprom start missing");

  property p_core_rst;
    @(posedge clk) disable iff (reset)
    (st_r.core_rst && !st_r.opt_srst && !wr) |=> (st_r.ev_mask == RST_EV && st_r.station == $past(st_r.station)
      && st_r.mode_pcmcia == $past(st_r.mode_pcmcia) && !eeprom_read_start);
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("core reset scope wrong");

  property p_pin_pd;
    @(posedge clk) disable iff (reset)
    pin_pd |=> (!modem_powerdown_out_n && tx_powered_down && rx_powered_down && link_powered_down);
  endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("pin power-down not applied");

  property p_local_wake_only;
    @(posedge clk) disable iff (reset)
    (!st_r.mode_pcmcia && !pin_pd && !st_r.ctl_legacy_powerdown_bit && st_r.ctl_wake)
      |=> (tx_powered_down && !rx_powered_down && !link_powered_down);
  endproperty
  a_local_wake_only: assert property (p_local_wake_only) else $error("tx-only state wrong");

  property p_local_legacy_powerdown_bit;
    @(posedge clk) disable iff (reset)
    (!st_r.mode_pcmcia && st_r.ctl_legacy_powerdown_bit) |=> (rx_powered_down && link_powered_down && tx_powered_down);
  endproperty
  a_local_legacy_powerdown_bit: assert property (p_local_legacy_powerdown_bit) else $error("legacy power-down ignored");

  property p_awake;
    @(posedge clk) disable iff (reset)
    (!st_r.mode_pcmcia && !pin_pd && !st_r.ctl_legacy_powerdown_bit && !st_r.ctl_wake)
      |=> (!tx_powered_down && !rx_powered_down && !link_powered_down && modem_powerdown_out_n);
  endproperty
  a_awake: assert property (p_awake) else $error("not fully awake");

  property p_strap;
    @(posedge clk) disable iff (reset)
    (st_r.rsync == RSYNC_DONE) |=> $stable(pcmcia_mode);
  endproperty
  a_strap: assert property (p_strap) else $error("mode resampled after reset");

  property p_ev_sticky;
    @(posedge clk) disable iff (reset)
    ((st_r.rsync == RSYNC_DONE) && !st_r.core_rst && !st_r.opt_srst)
      |=> ((st_r.ev_stat & $past(core_events)) == $past(core_events));
  endproperty
  a_ev_sticky: assert property (p_ev_sticky) else $error("event bit lost");

  property p_ev_clear;
    @(posedge clk) disable iff (reset)
    ((st_r.rsync == RSYNC_DONE) && wr && (addr == OFF_EV_STAT) && (core_events == RST_EV))
      |=> ((st_r.ev_stat & $past(wdata[EV_W-1:0])) == RST_EV);
  endproperty
  a_ev_clear: assert property (p_ev_clear) else $error("event bit not cleared");

  property p_card_lines;
    @(posedge clk) disable iff (reset)
    st_r.mode_pcmcia |=> (local_irq_pins == 4'h0);
  endproperty
  a_card_lines: assert property (p_card_lines) else $error("local pins active in card mode");

  property p_card_irq;
    @(posedge clk) disable iff (reset)
    (st_r.mode_pcmcia && (st_r.rsync == RSYNC_DONE) && !st_r.opt_srst && eth_irq && st_r.opt_irq_en)
      |=> !irq_ready_out_n;
  endproperty
  a_card_irq: assert property (p_card_irq) else $error("card request missing");

  property p_card_idle;
    @(posedge clk) disable iff (reset)
    (st_r.mode_pcmcia && (st_r.rsync == RSYNC_DONE) && !st_r.opt_srst && !(eth_irq && st_r.opt_irq_en))
      |=> irq_ready_out_n;
  endproperty
  a_card_idle: assert property (p_card_idle) else $error("card line low while idle");

  property p_card_ready;
    @(posedge clk) disable iff (reset)
    (pcmcia_mode && ($past(st_r.rsync) != RSYNC_DONE)) |-> !irq_ready_out_n;
  endproperty
  a_card_ready: assert property (p_card_ready) else $error("ready line high too early");

  property p_local_ready;
    @(posedge clk) disable iff (reset)
    (!st_r.mode_pcmcia && (st_r.rsync == RSYNC_DONE)) |=> irq_ready_out_n;
  endproperty
  a_local_ready: assert property (p_local_ready) else $error("card line low in local mode");

  property p_srst_scope;
    @(posedge clk) disable iff (reset)
    st_r.opt_srst |=> (st_r.station == RST_STATION && st_r.addr_a == RST_ADDR_A
      && st_r.ev_mask == RST_EV && !st_r.opt_func_en && !st_r.core_rst);
  endproperty
  a_srst_scope: assert property (p_srst_scope) else $error("soft reset scope wrong");

  property p_ee_release;
    @(posedge clk) disable iff (reset)
    (st_r.rsync == RSYNC_EDGE) |=> eeprom_read_start;
  endproperty
  a_ee_release: assert property (p_ee_release) else $error("no eeprom start after reset");

  property p_ee_quiet;
    @(posedge clk) disable iff (reset)
    ((st_r.rsync == RSYNC_DONE) && !(wr && (addr == OFF_OPTION) && wdata[OPT_SRST] && !st_r.opt_srst))
      |=> !eeprom_read_start;
  endproperty
  a_ee_quiet: assert property (p_ee_quiet) else $error("stray eeprom start");

  property p_wake_clear;
    @(posedge clk) disable iff (reset)
    (st_r.ctl_wake && wr && (addr == OFF_CONTROL) && !wdata[CTL_WAKE] && !wdata[CTL_LEGACY_POWERDOWN_BIT])
      |=> (!st_r.ctl_wake && !st_r.ctl_legacy_powerdown_bit);
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake clear not taken");

  property p_pin_keep;
    @(posedge clk) disable iff (reset)
    (pin_pd && !wr && !st_r.core_rst && !st_r.opt_srst)
      |=> ($stable(st_r.ctl_legacy_powerdown_bit) && $stable(st_r.ctl_wake));
  endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("control bits changed by pin");

  property p_pin_ignored;
    @(posedge clk) disable iff (reset)
    ((ext_endec_select == 2'h0) && !st_r.mode_pcmcia && !st_r.ctl_legacy_powerdown_bit)
      |=> (modem_powerdown_out_n && !rx_powered_down && !link_powered_down);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin used while unselected");

  property p_sync;
    @(posedge clk) disable iff (reset)
    (!powerdown_or_txclk_pin && (ext_endec_select != 2'h0) && st_r.pd_s1 && st_r.pd_s2)
      |=> !modem_powerdown_out_n;
  endproperty
  a_sync: assert property (p_sync) else $error("pin release not synchronised");
endmodule
`default_nettype wire

// ---- sim/irpc_host_model.sv ----
// Host CPU model that runs register bus cycles on the block
`timescale 1ns/1ps
`default_nettype none
module irpc_host_model
(
  input  wire logic                        clk,
  input  wire logic                        pcmcia_mode,
  input  wire logic [irpc_pkg::DATA_W-1:0] rdata,
  output var  logic [irpc_pkg::ADDR_W-1:0] addr,
  output var  logic [irpc_pkg::DATA_W-1:0] wdata,
  output var  logic                        wr,
  output var  logic                        rd
);
  import irpc_pkg::*;
  initial
  begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write; the status power-down bit is never set in local mode
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d;
    if (pcmcia_mode !== 1'b1 && a == OFF_STATUS) v[STS_PD] = 1'b0;
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask
  // One-cycle read; data taken in the cycle after the strobe
  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ---- sim/irq_reset_powerdown_ctrl_tb_top.sv ----
// Self-checking bench for the interrupt, reset and power-down block
`timescale 1ns/1ps
`default_nettype none
module irq_reset_powerdown_ctrl_tb_top;
  import irpc_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wr;
  logic              rd;
  logic [EV_W-1:0]   core_events = '0;
  logic              strap = 1'b0;
  logic              pin = 1'b0;
  logic [1:0]        sel = 2'h0;
  logic              ready_n;
  logic [3:0]        lpins;
  logic              irq;
  logic              modem_n;
  logic              tx_pd;
  logic              rx_pd;
  logic              link_pd;
  logic              ee;
  logic              mode;
  int                fails = 0;
  int                check_count = 0;
  int                ee_cnt = 0;
  int                e0;
  logic [3:0]        seq [6] = '{4'h0, 4'h2, 4'h0, 4'h3, 4'h1, 4'h0};
  always #10 clk = ~clk;
  always @(posedge clk) if (ee === 1'b1) ee_cnt <= ee_cnt + 1;
  irpc_ctrl irpc_ctrl_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .core_events(core_events), .bus_mode_strap(strap), .powerdown_or_txclk_pin(pin),
    .ext_endec_select(sel), .irq_ready_out_n(ready_n), .local_irq_pins(lpins), .irq(irq),
    .modem_powerdown_out_n(modem_n), .tx_powered_down(tx_pd), .rx_powered_down(rx_pd),
    .link_powered_down(link_pd), .eeprom_read_start(ee), .pcmcia_mode(mode));
  irpc_host_model irpc_host_model_inst (.clk(clk), .pcmcia_mode(mode), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin fails++; $display("BAD %s expected %h seen %h", n, e, g); end
  endtask
  task automatic chk_pins(input string n, input logic [3:0] e, input logic [3:0] g);
    check_count++;
    if (g !== e) begin fails++; $display("BAD %s expected %h seen %h", n, e, g); end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    irpc_host_model_inst.bus_write(a, d);
  endtask
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    irpc_host_model_inst.bus_read(a, d);
    chk_reg(n, e, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_ev(input logic [7:0] m);
    @(posedge clk);
    core_events <= m;
    @(posedge clk);
    core_events <= '0;
    settle(2);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    strap <= s;
    reset <= 1'b1;
    settle(4);
    chk_pins("reset lines", 4'h8, {modem_n, ready_n, irq, lpins[0]});
    e0 = ee_cnt;
    @(posedge clk);
    reset <= 1'b0;
    settle(1);
    chk_pins("early ready", {3'h0, ~s}, {3'h0, ready_n});
    settle(3);
    chk_reg("eeprom starts", 16'h0001, 16'(ee_cnt - e0));
  endtask
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial
  begin
    do_reset(1'b0);
    chk_pins("mode", 4'h0, {3'h0, mode});
    rd_chk("addr_a rst", OFF_ADDR_A, RST_ADDR_A);
    rd_chk("unmapped", 4'hf, 16'h0000);
    $display("Test reset done");
    wr_reg(OFF_OPTION, 16'h0010);
    wr_reg(OFF_EV_MASK, 16'h0004);
    pulse_ev(8'h08);
    chk_pins("masked irq", 4'h0, lpins);
    pulse_ev(8'h04);
    chk_pins("local pins", 4'h4, lpins);
    chk_pins("ready line", 4'h1, {3'h0, ready_n});
    rd_chk("status intr", OFF_STATUS, 16'h0001);
    wr_reg(OFF_EV_STAT, 16'h0004);
    rd_chk("ev stat", OFF_EV_STAT, 16'h0008);
    settle(2);
    chk_pins("cleared irq", 4'h0, {irq, lpins[2:0]});
    wr_reg(OFF_EV_STAT, 16'h0008);
    $display("Test interrupt done");
    foreach (seq[i])
    begin
      wr_reg(OFF_CONTROL, {12'h0, seq[i]});
      settle(2);
      chk_pins("power", {1'b1, seq[i][0], seq[i][0], |seq[i][1:0]}, {modem_n, link_pd, rx_pd, tx_pd});
    end
    wr_reg(OFF_CONTROL, 16'h0002);
    pin <= 1'b1;
    settle(6);
    chk_pins("pin unselected", 4'h9, {modem_n, link_pd, rx_pd, tx_pd});
    @(posedge clk);
    sel <= 2'h1;
    settle(6);
    chk_pins("pin down", 4'h7, {modem_n, link_pd, rx_pd, tx_pd});
    rd_chk("ctl kept", OFF_CONTROL, 16'h0002);
    @(posedge clk);
    pin <= 1'b0;
    settle(6);
    chk_pins("pin released", 4'h9, {modem_n, link_pd, rx_pd, tx_pd});
    $display("Test power done");
    wr_reg(OFF_STATION, 16'h1234);
    wr_reg(OFF_EV_MASK, 16'h00ff);
    e0 = ee_cnt;
    wr_reg(OFF_RXCTRL, 16'h0001);
    wr_reg(OFF_RXCTRL, 16'h0000);
    rd_chk("core mask", OFF_EV_MASK, 16'h0000);
    rd_chk("core ctl", OFF_CONTROL, 16'h0000);
    rd_chk("core station", OFF_STATION, 16'h1234);
    rd_chk("core option", OFF_OPTION, 16'h0010);
    chk_reg("core eeprom", 16'h0000, 16'(ee_cnt - e0));
    wr_reg(OFF_ADDR_A, 16'h5678);
    e0 = ee_cnt;
    wr_reg(OFF_OPTION, 16'h0004);
    wr_reg(OFF_OPTION, 16'h0000);
    settle(2);
    rd_chk("soft station", OFF_STATION, RST_STATION);
    rd_chk("soft addr_a", OFF_ADDR_A, RST_ADDR_A);
    chk_reg("soft eeprom", 16'h0001, 16'(ee_cnt - e0));
    chk_pins("soft mode", 4'h0, {3'h0, mode});
    $display("Test resets done");
    do_reset(1'b1);
    chk_pins("card ready", 4'h3, {2'h0, mode, ready_n});
    wr_reg(OFF_OPTION, 16'h0003);
    wr_reg(OFF_EV_MASK, 16'h0001);
    pulse_ev(8'h01);
    chk_pins("card irq", 4'h0, {ready_n, lpins[2:0]});
    wr_reg(OFF_EV_STAT, 16'h0001);
    settle(2);
    chk_pins("card clear", 4'h1, {3'h0, ready_n});
    wr_reg(OFF_OPTION, 16'h0004);
    settle(2);
    chk_pins("srst low", 4'h2, {2'h0, mode, ready_n});
    wr_reg(OFF_OPTION, 16'h0000);
    settle(3);
    chk_pins("srst raised", 4'h3, {2'h0, mode, ready_n});
    $display("Test card mode done");
    give_verdict();
  end
endmodule
`default_nettype wire
